// ### rtl/erbp_pkg.sv
// Constants, states and carriers for the external reset and boot pin sequencer
//
// How it works
// - Supply-ready input is active high despite its name; functional reset line is active low.
// - Drive reset line low during reset, release it on entering the final reset phase.
// - A qualified falling edge on the reset line starts a functional reset.
// - Stay in the final reset phase while the line is held low outside.
// - Power-up sequence waits until the supply-ready input goes high.
// - Configuration comes from fuse values plus boot switches, sampled in reset.
// - Boot mode is chosen from boot-select pins combined with configuration switches.
// - Boot-select pins only weakly pulled down; board sets levels externally.
package erbp_pkg;

  localparam int SEL_W       = 2;
  localparam int SW_W        = 8;
  localparam int FUSE_W      = 8;
  localparam int CFG_W       = SEL_W + SW_W + FUSE_W;

  localparam int CLK_HZ      = 10_000_000;
  // Input filter span; covers ramp bounce with a 100 us RC limit
  localparam int FILT_US     = 100;
  localparam int FILT_CYC    = (FILT_US * (CLK_HZ / 1_000_000) > 0) ?
                               FILT_US * (CLK_HZ / 1_000_000) : 1;
  // Length of the early reset phases
  localparam int PHASE_US    = 10;
  localparam int PHASE_CYC   = (PHASE_US * (CLK_HZ / 1_000_000) > 0) ?
                               PHASE_US * (CLK_HZ / 1_000_000) : 1;
  localparam int CNT_W       = 16;

  typedef enum logic [1:0] {
    ERBP_BOOT_SERIAL = 2'h0,
    ERBP_BOOT_FUSE   = 2'h1,
    ERBP_BOOT_SWITCH = 2'h2,
    ERBP_BOOT_TEST   = 2'h3
  } erbp_boot_t;

  typedef enum logic [2:0] {
    ERBP_ST_NOPWR,
    ERBP_ST_PH1,
    ERBP_ST_PH2,
    ERBP_ST_FINAL,
    ERBP_ST_RUN
  } erbp_state_t;

  typedef struct packed {
    logic [SEL_W-1:0]  bootSel;
    logic [SW_W-1:0]   switches;
    logic [FUSE_W-1:0] fuses;
  } erbp_cfg_t;

  typedef struct packed {
    erbp_boot_t        mode;
    logic [SW_W-1:0]   switches;
    logic [FUSE_W-1:0] fuses;
  } erbp_boot_cfg_t;

endpackage : erbp_pkg

// ### rtl/erbp_filter.sv
// Two-stage synchroniser followed by a stable-level filter
`timescale 1ns/10ps
module erbp_filter #(
  parameter int FILT_CYCLES = erbp_pkg::FILT_CYC,
  parameter bit RESET_LEVEL = 1'b0
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output logic      level
);
  import erbp_pkg::*;

  // Counter width limits the filter span
  if (FILT_CYCLES < 1 || FILT_CYCLES >= (1 << CNT_W)) begin : g_bad_filt
    $error("erbp_filter: FILT_CYCLES out of range");
  end

  logic             meta_ff;
  logic             sync_ff;
  logic [CNT_W-1:0] stable_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_ff <= RESET_LEVEL;
      sync_ff <= RESET_LEVEL;
    end else begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
    end
  end

  // Level changes only after the synced input holds for the full span
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stable_ff <= '0;
      level     <= RESET_LEVEL;
    end else if (sync_ff == level) begin
      stable_ff <= '0;
    end else if (stable_ff == CNT_W'(FILT_CYCLES - 1)) begin
      stable_ff <= '0;
      level     <= sync_ff;
    end else begin
      stable_ff <= stable_ff + CNT_W'(1);
    end
  end

  chk_filter_stable: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(level) |-> $past(sync_ff) == level)
    else $error("filtered level changed without synced input agreeing");

endmodule : erbp_filter

// ### rtl/erbp_sequencer.sv
// Reset sequencer: supply-ready wait, reset phases, reset pin drive, boot capture
`timescale 1ns/10ps
module erbp_sequencer #(
  parameter int FILT_CYCLES  = erbp_pkg::FILT_CYC,
  parameter int PHASE_CYCLES = erbp_pkg::PHASE_CYC
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   supply_ready_n,
  input  wire logic                   rstLineIn_n,
  output logic                        rstLineOut_n,
  output logic                        rstLineOe,
  input  wire logic [erbp_pkg::SEL_W-1:0]  boot_select_pins,
  input  wire logic [erbp_pkg::SW_W-1:0]   boot_cfg_switches,
  input  wire logic [erbp_pkg::FUSE_W-1:0] fuseValues,
  output logic                        coreRst_n,
  output logic                        funcRstStart,
  output erbp_pkg::erbp_boot_cfg_t    bootCfg,
  output logic                        bootCfgValid
);
  import erbp_pkg::*;

  // Counter width limits the phase length
  if (PHASE_CYCLES < 1 || PHASE_CYCLES >= (1 << CNT_W)) begin : g_bad_phase
    $error("erbp_sequencer: PHASE_CYCLES out of range");
  end

  logic        supplyLevel;
  logic        lineLevel;
  logic        lineLevel_ff;
  erbp_cfg_t   cfgMeta_ff;
  erbp_cfg_t   cfgSync_ff;
  erbp_state_t state_ff;
  erbp_state_t nxt_state;
  logic [CNT_W-1:0] phaseCnt_ff;
  logic        lineFall;
  logic        phaseDone;

  // Debounced, synchronised copies of the active-high supply and active-low line inputs
  // Supply filter starts at not powered, so nothing runs before a clean high
  erbp_filter #(.FILT_CYCLES(FILT_CYCLES), .RESET_LEVEL(1'b0)) u_supply_filt (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pinIn   (supply_ready_n),
    .level   (supplyLevel)
  );

  erbp_filter #(.FILT_CYCLES(FILT_CYCLES), .RESET_LEVEL(1'b0)) u_line_filt (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pinIn   (rstLineIn_n),
    .level   (lineLevel)
  );

  // Boot pins and switches come from the board, so they are synchronised too
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfgMeta_ff <= '0;
      cfgSync_ff <= '0;
    end else begin
      cfgMeta_ff <= '{boot_select_pins, boot_cfg_switches, fuseValues};
      cfgSync_ff <= cfgMeta_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lineLevel_ff <= 1'b0;
    end else begin
      lineLevel_ff <= lineLevel;
    end
  end

  // Only counted while running; our own drive low must not retrigger
  assign lineFall  = lineLevel_ff & ~lineLevel & (state_ff == ERBP_ST_RUN);
  assign phaseDone = (phaseCnt_ff == CNT_W'(PHASE_CYCLES - 1));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ERBP_ST_NOPWR: if (supplyLevel) nxt_state = ERBP_ST_PH1;
      ERBP_ST_PH1:   if (phaseDone) nxt_state = ERBP_ST_PH2;
      ERBP_ST_PH2:   if (phaseDone) nxt_state = ERBP_ST_FINAL;
      // Release the pin here so the outside can be seen holding it low
      ERBP_ST_FINAL: if (phaseDone && lineLevel) nxt_state = ERBP_ST_RUN;
      ERBP_ST_RUN:   if (lineFall) nxt_state = ERBP_ST_PH2;
      default:       nxt_state = ERBP_ST_NOPWR;
    endcase
    // Loss of supply always wins
    if (!supplyLevel) begin
      nxt_state = ERBP_ST_NOPWR;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= ERBP_ST_NOPWR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || nxt_state != state_ff) begin
      phaseCnt_ff <= '0;
    end else if (!phaseDone) begin
      phaseCnt_ff <= phaseCnt_ff + CNT_W'(1);
    end
  end

  // Pin drive: open-drain low until the final phase, then released to pull-up
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rstLineOut_n <= 1'b0;
      rstLineOe    <= 1'b1;
    end else begin
      rstLineOut_n <= 1'b0;
      rstLineOe    <= (nxt_state == ERBP_ST_NOPWR) || (nxt_state == ERBP_ST_PH1) ||
                      (nxt_state == ERBP_ST_PH2);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      coreRst_n    <= 1'b0;
      funcRstStart <= 1'b0;
    end else begin
      coreRst_n    <= (nxt_state == ERBP_ST_RUN);
      funcRstStart <= lineFall;
    end
  end

  function automatic erbp_boot_t decode_boot(input erbp_cfg_t c);
    erbp_boot_t m;
    m = erbp_boot_t'(c.bootSel);
    // Switch bit 0 lets a fuse-boot request fall back to the switches
    if (m == ERBP_BOOT_FUSE && c.switches[0]) begin
      m = ERBP_BOOT_SWITCH;
    end
    return m;
  endfunction : decode_boot

  // Captured through the whole reset, frozen when the device leaves reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bootCfg      <= '0;
      bootCfgValid <= 1'b0;
    end else if (nxt_state != ERBP_ST_RUN) begin
      bootCfg.mode     <= decode_boot(cfgSync_ff);
      bootCfg.switches <= cfgSync_ff.switches;
      bootCfg.fuses    <= cfgSync_ff.fuses;
      bootCfgValid     <= 1'b0;
    end else begin
      bootCfgValid <= 1'b1;
    end
  end

  chk_no_pwr_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !supplyLevel |=> !coreRst_n && rstLineOe)
    else $error("sequence advanced without supply ready");

  chk_drive_in_reset: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == ERBP_ST_PH1 || state_ff == ERBP_ST_PH2) |-> rstLineOe && !rstLineOut_n)
    else $error("reset line not driven low during reset phase");

  chk_release_run: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == ERBP_ST_RUN) |-> !rstLineOe && coreRst_n)
    else $error("reset line still driven while running");

  chk_fall_restart: assert property (@(posedge clock) disable iff (sys_rst)
    (lineFall && supplyLevel) |=> funcRstStart && state_ff == ERBP_ST_PH2 ##1 rstLineOe)
    else $error("falling edge did not start functional reset");

  chk_final_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == ERBP_ST_FINAL && !lineLevel) |=> state_ff != ERBP_ST_RUN)
    else $error("left final phase while line held low");

  chk_final_exit: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == ERBP_ST_FINAL && phaseDone && lineLevel && supplyLevel)
      |=> state_ff == ERBP_ST_RUN)
    else $error("final phase not left after line release");

  chk_cfg_frozen: assert property (@(posedge clock) disable iff (sys_rst)
    (bootCfgValid && $past(bootCfgValid)) |-> $stable(bootCfg))
    else $error("boot configuration changed while running");

  chk_boot_decode: assert property (@(posedge clock) disable iff (sys_rst)
    (nxt_state != ERBP_ST_RUN && cfgSync_ff.bootSel == 2'h0)
      |=> bootCfg.mode == ERBP_BOOT_SERIAL)
    else $error("boot mode not taken from boot-select pins");

  chk_active_low: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == ERBP_ST_NOPWR && !supplyLevel) [*2] |-> !coreRst_n)
    else $error("low supply-ready taken as powered");

  // Pin data stays low; only the enable decides whether the line is pulled
  chk_open_drain: assert property (@(posedge clock) disable iff (sys_rst)
    !rstLineOut_n)
    else $error("reset line data driven high");

  chk_start_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    funcRstStart |-> !coreRst_n && rstLineOe && $past(state_ff) == ERBP_ST_RUN)
    else $error("functional reset pulse outside a running device");

  chk_pulse_single: assert property (@(posedge clock) disable iff (sys_rst)
    funcRstStart |=> !funcRstStart)
    else $error("functional reset pulse longer than one cycle");

  chk_no_early_start: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == ERBP_ST_NOPWR && !supplyLevel) |=> state_ff == ERBP_ST_NOPWR)
    else $error("power-up sequence began before supply ready");

  chk_cfg_track: assert property (@(posedge clock) disable iff (sys_rst)
    (nxt_state != ERBP_ST_RUN) |=> bootCfg.fuses == $past(cfgSync_ff.fuses) && !bootCfgValid)
    else $error("boot configuration not captured during reset");

  chk_switch_fallback: assert property (@(posedge clock) disable iff (sys_rst)
    (nxt_state != ERBP_ST_RUN && cfgSync_ff.bootSel == 2'h1 && cfgSync_ff.switches[0])
      |=> bootCfg.mode == ERBP_BOOT_SWITCH)
    else $error("boot mode ignored configuration switch");

endmodule : erbp_sequencer

// ### bench/erbp_board_model.sv
// Board side: supply supervisor, reset line pull-up and external hold
`timescale 1ns/10ps
module erbp_board_model (
  input  wire logic railsOk,
  input  wire logic boardHold,
  input  wire logic rstLineOut_n,
  input  wire logic rstLineOe,
  output logic      supply_ready_n,
  output logic      rstLineIn_n
);
  // Held low until the critical rails pass the detect threshold
  assign supply_ready_n = railsOk;
  // Pull-up wins unless either party pulls the line low
  assign rstLineIn_n = ~((rstLineOe & ~rstLineOut_n) | boardHold);
endmodule : erbp_board_model

// ### bench/erbp_sequencer_tb_top.sv
// Self-checking bench for the reset and boot pin sequencer
`timescale 1ns/10ps
module erbp_sequencer_tb_top;
  import erbp_pkg::*;
  logic                clock = 1'b0;
  logic                sys_rst = 1'b1;
  logic                railsOk = 1'b0;
  logic                boardHold = 1'b0;
  logic [SEL_W-1:0]    boot_select_pins = '0;
  logic [SW_W-1:0]     boot_cfg_switches = '0;
  logic [FUSE_W-1:0]   fuseValues = '0;
  logic                supply_ready_n, rstLineIn_n, rstLineOut_n, rstLineOe;
  logic                coreRst_n, funcRstStart, bootCfgValid;
  erbp_boot_cfg_t      bootCfg;
  int                  nFail = 0;
  int                  compares = 0;
  int                  nPulse = 0;
  int                  cycles = 0;

  always #50 clock = ~clock;

  erbp_sequencer #(.FILT_CYCLES(4), .PHASE_CYCLES(3)) u_erbp_sequencer (
    .clock(clock), .sys_rst(sys_rst), .supply_ready_n(supply_ready_n),
    .rstLineIn_n(rstLineIn_n), .rstLineOut_n(rstLineOut_n), .rstLineOe(rstLineOe),
    .boot_select_pins(boot_select_pins), .boot_cfg_switches(boot_cfg_switches),
    .fuseValues(fuseValues), .coreRst_n(coreRst_n), .funcRstStart(funcRstStart),
    .bootCfg(bootCfg), .bootCfgValid(bootCfgValid));

  erbp_board_model u_erbp_board_model (
    .railsOk(railsOk), .boardHold(boardHold), .rstLineOut_n(rstLineOut_n),
    .rstLineOe(rstLineOe), .supply_ready_n(supply_ready_n), .rstLineIn_n(rstLineIn_n));

  always @(posedge clock) begin
    if (funcRstStart === 1'b1) nPulse <= nPulse + 1;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nFail++;
      wrapUp();
    end
  end

  task automatic chkBit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chkBit

  task automatic chkCfg(input erbp_boot_cfg_t exp, input erbp_boot_cfg_t got);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] bootCfg expected %h seen %h", exp, got);
    end
  endtask : chkCfg

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic waitCore(input logic val);
    for (int i = 0; i < 300 && coreRst_n !== val; i++) tick(1);
  endtask : waitCore

  task automatic powerUp(input logic [SEL_W-1:0] sel, input logic [SW_W-1:0] sw,
                         input logic [FUSE_W-1:0] fuse, input erbp_boot_t mode);
    erbp_boot_cfg_t exp;
    exp = '{mode, sw, fuse};
    @(posedge clock);
    sys_rst <= 1'b1;
    railsOk <= 1'b0;
    boot_select_pins <= sel;
    boot_cfg_switches <= sw;
    fuseValues <= fuse;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    tick(40);
    chkBit("coreRst_n before supply", 1'b0, coreRst_n);
    chkBit("rstLineOe in reset", 1'b1, rstLineOe);
    chkBit("rstLineOut_n", 1'b0, rstLineOut_n);
    @(posedge clock);
    railsOk <= 1'b1;
    waitCore(1'b1);
    chkBit("coreRst_n running", 1'b1, coreRst_n);
    chkBit("rstLineOe running", 1'b0, rstLineOe);
    chkBit("bootCfgValid", 1'b1, bootCfgValid);
    chkCfg(exp, bootCfg);
    @(posedge clock);
    boot_select_pins <= ~sel;
    boot_cfg_switches <= ~sw;
    tick(8);
    chkCfg(exp, bootCfg);
    $display("powerUp sel %h switches %h done", sel, sw);
  endtask : powerUp

  task automatic lineReset();
    int p0;
    p0 = nPulse;
    // Short dip must be taken for bounce
    @(posedge clock);
    boardHold <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    boardHold <= 1'b0;
    tick(20);
    chkBit("no pulse on glitch", 1'b1, nPulse == p0);
    chkBit("coreRst_n after glitch", 1'b1, coreRst_n);
    @(posedge clock);
    boardHold <= 1'b1;
    tick(12);
    chkBit("one start pulse", 1'b1, nPulse == p0 + 1);
    chkBit("coreRst_n in func reset", 1'b0, coreRst_n);
    tick(60);
    chkBit("held in final phase", 1'b0, coreRst_n);
    @(posedge clock);
    boardHold <= 1'b0;
    waitCore(1'b1);
    chkBit("coreRst_n after release", 1'b1, coreRst_n);
    chkBit("rstLineOe after release", 1'b0, rstLineOe);
    $display("lineReset done");
  endtask : lineReset

  task automatic supplyDrop();
    @(posedge clock);
    railsOk <= 1'b0;
    waitCore(1'b0);
    chkBit("coreRst_n on supply loss", 1'b0, coreRst_n);
    tick(2);
    chkBit("rstLineOe on supply loss", 1'b1, rstLineOe);
    @(posedge clock);
    railsOk <= 1'b1;
    waitCore(1'b1);
    chkBit("coreRst_n supply back", 1'b1, coreRst_n);
    $display("supplyDrop done");
  endtask : supplyDrop

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrapUp

  initial begin
    powerUp(2'h0, 8'h5A, 8'hC3, ERBP_BOOT_SERIAL);
    powerUp(2'h1, 8'h3C, 8'h81, ERBP_BOOT_FUSE);
    powerUp(2'h1, 8'hA5, 8'h7E, ERBP_BOOT_SWITCH);
    powerUp(2'h3, 8'hF1, 8'h0F, ERBP_BOOT_TEST);
    powerUp(2'h2, 8'h96, 8'h69, ERBP_BOOT_SWITCH);
    lineReset();
    lineReset();
    supplyDrop();
    wrapUp();
  end
endmodule : erbp_sequencer_tb_top
